// ### rtl/deser_output_config_power_ctrl.v
// Configuration, output control and power states of the link receiver
//
// How it works
// - Equalizer off when gain bit 0 low; upper bits pick 1.5 dB steps.
// - Clock output and data output edge rates set separately; high is fast.
// - A low edge-rate setting selects the slowest edges for its outputs.
// - Enabled spread modulates clock and data outputs, up to 2 %, 100 kHz.
// - Code zero disables spread; deviation index is code minus one mod 4.
// - Normal mode groups codes by four: divide by 2168, 1300, 868, 650.
// - Low-frequency mode groups: divide by 620, 370, 258, 192.
// - Power down while the power-down pin is low, run while high.
// - Entering power down returns all bus registers to defaults.
// - Auto-detect powers down on lost stream, relocks when it returns.
// - In power down, output state select sets clock and data outputs.
// - Without auto-detect, missing embedded clock bits mean a stopped stream and sleep.
// - Leaving sleep relocks; sleep keeps bus register contents.
// - Lost stream clock drives lock low, outputs per state select.
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
`include "deser_cfg_regs.vh"
module deser_output_config_power_ctrl (
  input  wire        clk_i,            // Recovered parallel clock, 125 MHz
  input  wire        rst_i,            // Synchronous reset, high
  input  wire        wb_cyc_i,         // Wishbone cycle
  input  wire        wb_stb_i,         // Wishbone strobe
  input  wire        wb_we_i,          // Wishbone write enable
  input  wire [7:0]  wb_adr_i,         // Wishbone byte address
  input  wire [31:0] wb_dat_i,         // Wishbone write data
  input  wire [3:0]  wb_sel_i,         // Wishbone byte selects
  output reg  [31:0] wb_dat_o,         // Wishbone read data
  output reg         wb_ack_o,         // Wishbone acknowledge
  input  wire        power_down_n_i,   // Power-down pin, low powers down
  input  wire        stream_present_i, // Embedded clock bits seen
  input  wire [3:0]  strap_gain_i,     // Strap, rx_gain_select
  input  wire        strap_clk_rate_i, // Strap, clk_out_edge_rate
  input  wire        strap_data_rate_i,// Strap, data_out_edge_rate
  input  wire [3:0]  strap_spread_i,   // Strap, spread_code
  input  wire        strap_lf_i,       // Strap, low_freq_spread_mode
  input  wire        strap_oss_i,      // Strap, output_state_select
  input  wire        strap_auto_i,     // Strap, auto-detect power down
  output reg         rx_eq_en_o,       // Receive equalizer on
  output reg  [2:0]  rx_gain_o,        // Gain step, 0 is 1.5 dB
  output reg         clk_edge_fast_o,  // Fast edges on clock output
  output reg         data_edge_fast_o, // Fast edges on data outputs
  output reg         spread_en_o,      // Spread modulation enabled
  output reg  [1:0]  spread_dev_o,     // Deviation index, 0.5 % steps
  output reg  [11:0] spread_div_o,     // Cycles per modulation period
  output reg  [4:0]  spread_offset_o,  // Live modulation offset
  output reg         out_oe_o,         // Clock and data outputs driven
  output reg         clk_out_en_o,     // Recovered clock passed to output
  output reg         data_out_en_o,    // Recovered data passed to outputs
  output reg         lock_o,           // Lock indicator level
  output reg         lock_oe_o,        // Lock indicator driven
  output reg         powered_down_o,   // Block is in power down
  output reg         sleep_o           // Block is in stream-stop sleep
);

  // ****************************************
  // States
  // ****************************************
  localparam [3:0] ST_PDOWN   = 4'b0001;
  localparam [3:0] ST_ACQUIRE = 4'b0010;
  localparam [3:0] ST_LOCKED  = 4'b0100;
  localparam [3:0] ST_SLEEP   = 4'b1000;

  reg  [3:0]  state_reg;
  reg  [3:0]  state_next;
  reg  [7:0]  lock_cnt_reg;
  reg  [31:0] cfg_reg;
  reg  [31:0] cfg_next;
  reg  [12:0] strap_reg;
  reg  [12:0] strap_s1_reg;
  reg  [12:0] strap_s2_reg;
  reg  [12:0] strap_s3_reg;
  reg         pdn_s1_reg;
  reg         pdn_s2_reg;
  reg         pdn_s3_reg;
  reg         pdn_lvl_reg;
  reg         str_s1_reg;
  reg         str_s2_reg;
  reg         str_s3_reg;
  reg         str_lvl_reg;
  reg  [31:0] rd_data;
  reg  [11:0] div_sel;
  wire [31:0] lane_mask;
  wire [12:0] eff;
  wire        pd_state;
  wire        wb_req;
  wire        cfg_wr;
  wire [3:0]  code;
  wire [3:0]  code_m1;
  wire        spread_on;
  wire        auto_mode;
  wire        oss;
  wire [4:0]  offset;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // A change counts only once the second and third stages agree
  always @(posedge clk_i) begin
    if (rst_i) begin
      pdn_s1_reg  <= 1'b0;
      pdn_s2_reg  <= 1'b0;
      pdn_s3_reg  <= 1'b0;
      pdn_lvl_reg <= 1'b0;
      str_s1_reg  <= 1'b0;
      str_s2_reg  <= 1'b0;
      str_s3_reg  <= 1'b0;
      str_lvl_reg <= 1'b0;
    end else begin
      pdn_s1_reg <= power_down_n_i;
      pdn_s2_reg <= pdn_s1_reg;
      pdn_s3_reg <= pdn_s2_reg;
      str_s1_reg <= stream_present_i;
      str_s2_reg <= str_s1_reg;
      str_s3_reg <= str_s2_reg;
      if (pdn_s2_reg == pdn_s3_reg) begin
        pdn_lvl_reg <= pdn_s3_reg;
      end
      if (str_s2_reg == str_s3_reg) begin
        str_lvl_reg <= str_s3_reg;
      end
    end
  end

  // ****************************************
  // Strap capture
  // ****************************************
  // Straps are sampled while leaving power down, as on a power-up
  always @(posedge clk_i) begin
    if (rst_i) begin
      strap_s1_reg <= 13'h0000;
      strap_s2_reg <= 13'h0000;
      strap_s3_reg <= 13'h0000;
      strap_reg    <= 13'h0000;
    end else begin
      strap_s1_reg <= {strap_auto_i, strap_oss_i, strap_lf_i, strap_spread_i,
                       strap_data_rate_i, strap_clk_rate_i, strap_gain_i};
      strap_s2_reg <= strap_s1_reg;
      strap_s3_reg <= strap_s2_reg;
      // Straps are pins too: take them only once two stages agree
      if (state_reg == ST_PDOWN && pdn_lvl_reg &&
          strap_s2_reg == strap_s3_reg) begin
        strap_reg <= strap_s3_reg;
      end
    end
  end

  // ****************************************
  // Register or strap selection
  // ****************************************
  assign eff       = cfg_reg[`CFG_REG_CTRL] ? cfg_reg[12:0] : strap_reg;
  assign code      = eff[`CFG_SPREAD_MSB:`CFG_SPREAD_LSB];
  assign code_m1   = code - 4'd1;
  assign spread_on = (code != 4'h0);
  assign auto_mode = eff[`CFG_AUTO];
  assign oss       = eff[`CFG_OSS];
  assign pd_state  = (state_reg == ST_PDOWN);

  // ****************************************
  // Power state machine
  // ****************************************
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_PDOWN: begin
        // Auto-detect waits in power down for the stream to return
        if (pdn_lvl_reg && (!auto_mode || str_lvl_reg)) begin
          state_next = ST_ACQUIRE;
        end
      end
      ST_ACQUIRE: begin
        if (!str_lvl_reg) begin
          state_next = auto_mode ? ST_PDOWN : ST_SLEEP;
        end else if (lock_cnt_reg == `LOCK_CYCLES) begin
          state_next = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        if (!str_lvl_reg) begin
          state_next = auto_mode ? ST_PDOWN : ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (str_lvl_reg) begin
          state_next = ST_ACQUIRE;
        end
      end
      default: begin
        state_next = ST_PDOWN;
      end
    endcase
    if (!pdn_lvl_reg) begin
      state_next = ST_PDOWN;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg    <= ST_PDOWN;
      lock_cnt_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_ACQUIRE && state_next == ST_ACQUIRE) begin
        lock_cnt_reg <= lock_cnt_reg + 8'd1;
      end else begin
        lock_cnt_reg <= 8'h00;
      end
    end
  end

  // ****************************************
  // Wishbone slave
  // ****************************************
  // One wait state: ack follows the request by one edge, then drops
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign cfg_wr = wb_req && wb_we_i && (wb_adr_i == `OFF_CFG);

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      assign lane_mask[lane*8 +: 8] = {8{wb_sel_i[lane]}};
    end
  endgenerate

  always @* begin
    cfg_next = cfg_reg;
    if (cfg_wr) begin
      cfg_next = ((cfg_reg & ~lane_mask) | (wb_dat_i & lane_mask))
                 & `CFG_MASK;
    end
  end

  always @* begin
    rd_data = 32'h00000000;
    if (wb_adr_i == `OFF_CFG) begin
      rd_data = cfg_reg;
    end else if (wb_adr_i == `OFF_STATUS) begin
      rd_data[`ST_LOCK]   = (state_reg == ST_LOCKED);
      rd_data[`ST_PDOWN]  = pd_state;
      rd_data[`ST_SLEEP]  = (state_reg == ST_SLEEP);
      rd_data[`ST_STREAM] = str_lvl_reg;
      rd_data[`ST_SPREAD] = spread_on;
      rd_data[`ST_DEV_MSB:`ST_DEV_LSB] = code_m1[1:0];
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  // Power down clears the map and ignores writes; sleep leaves it alone
  always @(posedge clk_i) begin
    if (rst_i || pd_state) begin
      cfg_reg <= `CFG_RST;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // ****************************************
  // Spread code decode
  // ****************************************
  always @* begin
    div_sel = `DIV_N0;
    if (eff[`CFG_LOW_FREQ_SPREAD_MODE]) begin
      case (code_m1[3:2])
        2'd0:    div_sel = `DIV_L0;
        2'd1:    div_sel = `DIV_L1;
        2'd2:    div_sel = `DIV_L2;
        default: div_sel = `DIV_L3;
      endcase
    end else begin
      case (code_m1[3:2])
        2'd0:    div_sel = `DIV_N0;
        2'd1:    div_sel = `DIV_N1;
        2'd2:    div_sel = `DIV_N2;
        default: div_sel = `DIV_N3;
      endcase
    end
  end

  // Modulation only runs while the recovered clock is passed out
  spread_clock_gen u_spread (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .en_i     (spread_on && state_reg == ST_LOCKED),
    .div_i    (div_sel),
    .dev_i    (code_m1[1:0]),
    .offset_o (offset)
  );

  // ****************************************
  // Output registers
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_eq_en_o       <= 1'b0;
      rx_gain_o        <= 3'h0;
      clk_edge_fast_o  <= 1'b0;
      data_edge_fast_o <= 1'b0;
      spread_en_o      <= 1'b0;
      spread_dev_o     <= 2'h0;
      spread_div_o     <= 12'h000;
      spread_offset_o  <= 5'h00;
    end else begin
      rx_eq_en_o       <= eff[`CFG_GAIN_LSB];
      rx_gain_o        <= eff[`CFG_GAIN_LSB] ?
                          eff[`CFG_GAIN_MSB:`CFG_GAIN_LSB+1] : 3'h0;
      clk_edge_fast_o  <= eff[`CFG_CLK_RATE];
      data_edge_fast_o <= eff[`CFG_DATA_RATE];
      spread_en_o      <= spread_on;
      spread_dev_o     <= spread_on ? code_m1[1:0] : 2'h0;
      spread_div_o     <= spread_on ? div_sel : 12'h000;
      // Zero offset leaves clock and data unmodulated
      // Gated by the next state so it drops together with lock
      spread_offset_o  <= (spread_on && state_next == ST_LOCKED) ?
                          offset : 5'h00;
    end
  end

  // Pin states per power state and output state select
  always @(posedge clk_i) begin
    if (rst_i) begin
      out_oe_o       <= 1'b0;
      clk_out_en_o   <= 1'b0;
      data_out_en_o  <= 1'b0;
      lock_o         <= 1'b0;
      lock_oe_o      <= 1'b0;
      powered_down_o <= 1'b1;
      sleep_o        <= 1'b0;
    end else begin
      powered_down_o <= (state_next == ST_PDOWN);
      sleep_o        <= (state_next == ST_SLEEP);
      lock_o         <= (state_next == ST_LOCKED);
      clk_out_en_o   <= (state_next == ST_LOCKED);
      data_out_en_o  <= (state_next == ST_LOCKED);
      if (state_next == ST_LOCKED) begin
        out_oe_o  <= 1'b1;
        lock_oe_o <= 1'b1;
      end else if (state_next == ST_PDOWN && !pdn_lvl_reg) begin
        out_oe_o  <= oss;
        lock_oe_o <= oss;
      end else begin
        // Acquiring or stream absent: lock driven low, outputs low or released
        out_oe_o  <= oss;
        lock_oe_o <= 1'b1;
      end
    end
  end

endmodule

// ### rtl/deser_cfg_regs.vh
// Register map, field positions, reset values and counts of the link control
`ifndef DESER_CFG_REGS_VH
`define DESER_CFG_REGS_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define OFF_CFG          8'h00
`define OFF_STATUS       8'h04

// ****************************************
// Configuration register fields
// ****************************************
`define CFG_GAIN_LSB     0
`define CFG_GAIN_MSB     3
`define CFG_CLK_RATE     4
`define CFG_DATA_RATE    5
`define CFG_SPREAD_LSB   6
`define CFG_SPREAD_MSB   9
`define CFG_LOW_FREQ_SPREAD_MODE      10
`define CFG_OSS          11
`define CFG_AUTO         12
`define CFG_REG_CTRL     31
`define CFG_RST          32'h00000000
`define CFG_MASK         32'h80001FFF

// ****************************************
// Status register fields
// ****************************************
`define ST_LOCK          0
`define ST_PDOWN         1
`define ST_SLEEP         2
`define ST_STREAM        3
`define ST_SPREAD        4
`define ST_DEV_LSB       5
`define ST_DEV_MSB       6

// ****************************************
// Modulation divisors, normal and low-frequency mode
// ****************************************
`define DIV_N0           12'd2168
`define DIV_N1           12'd1300
`define DIV_N2           12'd868
`define DIV_N3           12'd650
`define DIV_L0           12'd620
`define DIV_L1           12'd370
`define DIV_L2           12'd258
`define DIV_L3           12'd192

// ****************************************
// Timing counts
// ****************************************
`define LOCK_CYCLES      8'd64

`endif

// ### rtl/spread_clock_gen.v
// Triangle modulation generator for the spread output clock
`timescale 1ns/10ps
module spread_clock_gen (
  input  wire        clk_i,     // Recovered parallel clock
  input  wire        rst_i,     // Synchronous reset, high
  input  wire        en_i,      // Modulation enable
  input  wire [11:0] div_i,     // Clock cycles per modulation period
  input  wire [1:0]  dev_i,     // Deviation index, 0.5 % steps
  output reg  [4:0]  offset_o   // Frequency offset, zero means none
);

  reg  [7:0] step_cnt_reg;
  reg  [3:0] pos_reg;
  wire [7:0] step_len;
  wire [2:0] tri_val;
  wire [4:0] scaled;

  // Sixteen steps per period, so one step is div/16 cycles
  assign step_len = div_i[11:4];
  assign tri_val  = pos_reg[3] ? ~pos_reg[2:0] : pos_reg[2:0];
  assign scaled   = tri_val * ({3'b000, dev_i} + 5'd1);

  always @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      step_cnt_reg <= 8'h00;
      pos_reg      <= 4'h0;
      offset_o     <= 5'h00;
    end else begin
      if (step_cnt_reg >= step_len - 8'd1) begin
        step_cnt_reg <= 8'h00;
        pos_reg      <= pos_reg + 4'd1;
      end else begin
        step_cnt_reg <= step_cnt_reg + 8'd1;
      end
      offset_o <= scaled;
    end
  end

endmodule

// ### testbench/ser_stream_model.sv
// Behavioural serializer: sends embedded clock bits while running
`timescale 1ns/10ps
module ser_stream_model #(
  parameter int START_DLY = 20         // Cycles before bits appear
) (
  input  wire logic clk_i,             // Parallel clock
  input  wire logic run_i,             // Serializer sending
  output logic      stream_present_o   // Embedded clock bits seen
);
  int cnt = 0;
  initial stream_present_o = 1'b0;
  // A stop is seen at once, a restart only after the start delay
  always @(posedge clk_i) begin
    cnt <= run_i ? cnt + 1 : 0;
    stream_present_o <= run_i && (cnt >= START_DLY);
  end
endmodule

// ### testbench/deser_output_config_power_ctrl_chk.sv
// Checker of output, spread and power state relations
`timescale 1ns/10ps
module deser_output_config_power_ctrl_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        power_down_n_i,
  input wire logic        stream_present_i,
  input wire logic        rx_eq_en_o,
  input wire logic [2:0]  rx_gain_o,
  input wire logic        spread_en_o,
  input wire logic [1:0]  spread_dev_o,
  input wire logic [11:0] spread_div_o,
  input wire logic [4:0]  spread_offset_o,
  input wire logic        out_oe_o,
  input wire logic        clk_out_en_o,
  input wire logic        data_out_en_o,
  input wire logic        lock_o,
  input wire logic        lock_oe_o,
  input wire logic        powered_down_o,
  input wire logic        sleep_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  eq_off_a: assert property (!rx_eq_en_o |-> rx_gain_o == 3'h0)
    else $error("gain while off");
  spread_off_a: assert property (!spread_en_o |->
    spread_dev_o == 2'h0 && spread_div_o == 12'h000) else $error("spread off");
  no_mod_a: assert property (!(spread_en_o && lock_o)
    |-> spread_offset_o == 5'h00) else $error("modulated clock");
  div_legal_a: assert property (spread_en_o |-> spread_div_o inside
    {12'd2168, 12'd1300, 12'd868, 12'd650, 12'd620, 12'd370, 12'd258,
     12'd192}) else $error("bad divisor");
  pin_down_a: assert property (!power_down_n_i [*6] |->
    powered_down_o && !lock_o) else $error("pin not powering down");
  pd_out_a: assert property (powered_down_o |->
    !clk_out_en_o && !data_out_en_o && !lock_o) else $error("live in pd");
  loss_lock_a: assert property (!stream_present_i [*6] |->
    !lock_o) else $error("lock kept");
  lock_live_a: assert property (lock_o |-> out_oe_o &&
    lock_oe_o && clk_out_en_o && data_out_en_o) else $error("lock dead");
  sleep_lock_a: assert property (sleep_o |-> !lock_o)
    else $error("lock in sleep");
  cover property (lock_o);
  cover property (sleep_o);
  cover property (spread_en_o && lock_o);
endmodule
bind deser_output_config_power_ctrl deser_output_config_power_ctrl_chk
  chk (.*);

// ### testbench/deser_output_config_power_ctrl_tb.sv
// Testbench: register, spread, sleep and power-down sequences
`timescale 1ns/10ps
`include "deser_cfg_regs.vh"
module deser_output_config_power_ctrl_tb;
  logic        clk_i = 0, rst_i = 1, run = 0;
  logic        wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd_v, v;
  logic [3:0]  wb_sel_i = 4'hF, strap_gain_i = 4'hB, strap_spread_i = 4'h6;
  logic        power_down_n_i = 0, stream_present_i, wb_ack_o;
  logic        strap_clk_rate_i = 1, strap_data_rate_i = 0, strap_lf_i = 0;
  logic        strap_oss_i = 1, strap_auto_i = 1;
  logic [4:0]  mx;
  logic        rx_eq_en_o, clk_edge_fast_o, data_edge_fast_o, spread_en_o;
  logic [2:0]  rx_gain_o;
  logic [1:0]  spread_dev_o;
  logic [11:0] spread_div_o;
  logic [4:0]  spread_offset_o;
  logic        out_oe_o, clk_out_en_o, data_out_en_o, lock_o, lock_oe_o;
  logic        powered_down_o, sleep_o;
  int          miscompares = 0, n_compared = 0, cyc = 0;
  int          nd[4] = '{2168, 1300, 868, 650};
  int          ld[4] = '{620, 370, 258, 192};
  deser_output_config_power_ctrl DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .power_down_n_i(power_down_n_i), .stream_present_i(stream_present_i),
    .strap_gain_i(strap_gain_i), .strap_clk_rate_i(strap_clk_rate_i),
    .strap_data_rate_i(strap_data_rate_i),
    .strap_spread_i(strap_spread_i), .strap_lf_i(strap_lf_i),
    .strap_oss_i(strap_oss_i), .strap_auto_i(strap_auto_i),
    .rx_eq_en_o(rx_eq_en_o), .rx_gain_o(rx_gain_o),
    .clk_edge_fast_o(clk_edge_fast_o), .data_edge_fast_o(data_edge_fast_o),
    .spread_en_o(spread_en_o), .spread_dev_o(spread_dev_o),
    .spread_div_o(spread_div_o), .spread_offset_o(spread_offset_o),
    .out_oe_o(out_oe_o), .clk_out_en_o(clk_out_en_o),
    .data_out_en_o(data_out_en_o), .lock_o(lock_o), .lock_oe_o(lock_oe_o),
    .powered_down_o(powered_down_o), .sleep_o(sleep_o));
  ser_stream_model SER (.clk_i(clk_i), .run_i(run),
    .stream_present_o(stream_present_i));
  always #4 clk_i = ~clk_i;
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      final_report;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd_v = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    wb_we_i <= 0;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    power_down_n_i <= 1;
    run <= 1;
    while (lock_o !== 1'b1) @(posedge clk_i);
    @(posedge clk_i);
    chk(lock_o, 1);
    chk(rx_eq_en_o, 1);
    chk(rx_gain_o, 5);
    chk(clk_edge_fast_o, 1);
    chk(data_edge_fast_o, 0);
    chk(spread_dev_o, 1);
    chk(spread_div_o, 1300);
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 16; i++) begin
        v = 32'h80000000 | (j << 10) | (i << 6) | (((i >> 1) & 3) << 4) | i;
        wb(1, `OFF_CFG, v);
        repeat (3) @(posedge clk_i);
        chk(rx_eq_en_o, i & 1);
        chk(rx_gain_o, (i & 1) ? (i >> 1) : 0);
        chk(clk_edge_fast_o, (i >> 1) & 1);
        chk(data_edge_fast_o, (i >> 2) & 1);
        chk(spread_en_o, i != 0);
        chk(spread_dev_o, i ? (i - 1) & 3 : 0);
        chk(spread_div_o, i ? (j ? ld[(i-1)>>2] : nd[(i-1)>>2]) : 0);
      end
    end
    // Code 15 in low-frequency mode: index 2, peak offset 7 * 3
    mx = 5'h00;
    repeat (400) begin
      @(posedge clk_i);
      if (spread_offset_o > mx)
        mx = spread_offset_o;
    end
    chk(mx, 21);
    wb(0, 8'h08, 0);
    chk(rd_v, 0);
    run <= 0;
    while (sleep_o !== 1'b1) @(posedge clk_i);
    chk(lock_o, 0);
    chk(out_oe_o, 0);
    chk(lock_oe_o, 1);
    wb(0, `OFF_CFG, 0);
    chk(rd_v, v & `CFG_MASK);
    run <= 1;
    while (lock_o !== 1'b1) @(posedge clk_i);
    chk(sleep_o, 0);
    wb(1, `OFF_CFG, v | 32'h1000);
    run <= 0;
    while (powered_down_o !== 1'b1) @(posedge clk_i);
    wb(0, `OFF_CFG, 0);
    chk(rd_v, 0);
    chk(powered_down_o, 1);
    chk(lock_o, 0);
    run <= 1;
    while (lock_o !== 1'b1) @(posedge clk_i);
    chk(powered_down_o, 0);
    power_down_n_i <= 0;
    while (powered_down_o !== 1'b1) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
    chk(out_oe_o, 1);
    chk(lock_oe_o, 1);
    chk(lock_o, 0);
    wb(1, `OFF_CFG, 32'h80000001);
    wb(0, `OFF_CFG, 0);
    chk(rd_v, 0);
    final_report;
  end
endmodule
